/* rtl/epr_defs.vh */
// register map, field positions and defaults of the enable pin routing bank
`ifndef EPR_DEFS_VH
`define EPR_DEFS_VH

// printed offsets are register indices, not all multiples of four
`define EPR_IDX_PIN3_LINEAR 8'h33
`define EPR_IDX_PIN3_CONVERTER 8'h34
`define EPR_IDX_PIN4_LINEAR 8'h35
`define EPR_IDX_PIN4_CONVERTER 8'h36
`define EPR_ADDR_W 8
`define EPR_REG_W 8
`define EPR_CONV_W 6
`define EPR_LIN_LO 0
`define EPR_LIN_HI 7
`define EPR_CNV_LIN9 0
`define EPR_CNV_LIN10 1
`define EPR_CNV_BUCK_LO 2
`define EPR_CNV_BUCK_HI 5
`define EPR_NUM_LINEAR 10
`define EPR_NUM_BUCK 4
`define EPR_NUM_REG 14
`define EPR_DEF_PIN3_LINEAR 8'h00
`define EPR_DEF_PIN3_CONVERTER 6'h00
`define EPR_DEF_PIN4_LINEAR 8'h00
`define EPR_DEF_PIN4_CONVERTER 6'h00
`define EPR_ZERO_8 8'h00
`define EPR_ZERO_32 32'h0000_0000
`define EPR_RESERVED_BITS_ZERO 2'h0
`define EPR_RSP_OKAY 2'h0
`define EPR_RSP_SLVERR 2'h2
`define EPR_PAD_24 24'h00_0000
`define EPR_ZERO_10 10'h000
`define EPR_ZERO_4 4'h0

`endif

/* rtl/epr_regs.v */
// enable pin routing register bank with avalon-mm slave and pin gating
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

`include "epr_defs.vh"

// Notes on behaviour
// - index 33h bits 7..0 route third enable pin to linear regulators 8..1.
// - index 34h bits 5..2 bucks 4..1, bits 1..0 linear 10,9 for third pin.
// - index 35h bits 7..0 route fourth enable pin to linear regulators 8..1.
// - index 36h bits 5..2 bucks 4..1, bits 1..0 linear 10,9 for fourth pin.
// - converter-select bits 7 and 6 read zero; writes to them are ignored.
// - all four routing registers return to defaults on power-on reset.
// - cleared select bit leaves that pin without influence on the regulator.
module epr_regs #(
   parameter [7:0] DEF_PIN3_LINEAR = `EPR_DEF_PIN3_LINEAR,
   parameter [5:0] DEF_PIN3_CONVERTER = `EPR_DEF_PIN3_CONVERTER,
   parameter [7:0] DEF_PIN4_LINEAR = `EPR_DEF_PIN4_LINEAR,
   parameter [5:0] DEF_PIN4_CONVERTER = `EPR_DEF_PIN4_CONVERTER
) (
   input wire sys_clk,
   input wire resetn,
   input wire [9:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg [1:0] avs_response,
   input wire third_enable_pin,
   input wire fourth_enable_pin,
   output reg [9:0] linear_pin_enable,
   output reg [3:0] buck_pin_enable,
   output reg [9:0] linear_pin3_route,
   output reg [3:0] buck_pin3_route,
   output reg [9:0] linear_pin4_route,
   output reg [3:0] buck_pin4_route
);

////////////////////////////////////////////////////////////////////////////////
// registers and pin synchronisers

reg [7:0] pin3_linear_select_r;
reg [5:0] pin3_converter_select_r;
reg [7:0] pin4_linear_select_r;
reg [5:0] pin4_converter_select_r;
reg [1:0] pin3_sync_r;
reg [1:0] pin4_sync_r;
reg busy_r;
wire [7:0] reg_index;
wire hit;
wire req;
wire [9:0] lin3_sel;
wire [9:0] lin4_sel;
wire [3:0] buck3_sel;
wire [3:0] buck4_sel;
reg [7:0] rd_byte;

// word index = byte address / 4
assign reg_index = avs_address[9:2];
assign req = (avs_read | avs_write) & ~busy_r;
assign hit = (reg_index == `EPR_IDX_PIN3_LINEAR) || (reg_index == `EPR_IDX_PIN3_CONVERTER) ||
   (reg_index == `EPR_IDX_PIN4_LINEAR) || (reg_index == `EPR_IDX_PIN4_CONVERTER);

always @(posedge sys_clk) begin
   if (!resetn) begin
      pin3_sync_r <= 2'b00;
      pin4_sync_r <= 2'b00;
   end else begin
      pin3_sync_r <= {pin3_sync_r[0], third_enable_pin};
      pin4_sync_r <= {pin4_sync_r[0], fourth_enable_pin};
   end
end

////////////////////////////////////////////////////////////////////////////////
// read mux

always @* begin
   case (reg_index)
      `EPR_IDX_PIN3_LINEAR: rd_byte = pin3_linear_select_r;
      `EPR_IDX_PIN3_CONVERTER: rd_byte = {`EPR_RESERVED_BITS_ZERO, pin3_converter_select_r};
      `EPR_IDX_PIN4_LINEAR: rd_byte = pin4_linear_select_r;
      `EPR_IDX_PIN4_CONVERTER: rd_byte = {`EPR_RESERVED_BITS_ZERO, pin4_converter_select_r};
      default: rd_byte = `EPR_ZERO_8;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, answer on the second edge of the request

always @(posedge sys_clk) begin
   if (!resetn) begin
      // power-on reset reloads programmed defaults
      pin3_linear_select_r <= DEF_PIN3_LINEAR;
      pin3_converter_select_r <= DEF_PIN3_CONVERTER;
      pin4_linear_select_r <= DEF_PIN4_LINEAR;
      pin4_converter_select_r <= DEF_PIN4_CONVERTER;
      busy_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= `EPR_ZERO_32;
      avs_response <= `EPR_RSP_OKAY;
   end else begin
      busy_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      if (req) begin
         busy_r <= 1'b1;
         avs_waitrequest <= 1'b0;
         // unmapped index answers slave error, reads zero
         avs_response <= hit ? `EPR_RSP_OKAY : `EPR_RSP_SLVERR;
         avs_readdata <= avs_read ? {`EPR_PAD_24, rd_byte} : `EPR_ZERO_32;
         if (avs_write && avs_byteenable[0]) begin
            case (reg_index)
               `EPR_IDX_PIN3_LINEAR: pin3_linear_select_r <= avs_writedata[7:0];
               `EPR_IDX_PIN3_CONVERTER:
                  pin3_converter_select_r <= avs_writedata[5:0];
               `EPR_IDX_PIN4_LINEAR: pin4_linear_select_r <= avs_writedata[7:0];
               `EPR_IDX_PIN4_CONVERTER:
                  pin4_converter_select_r <= avs_writedata[5:0];
               default: ;
            endcase
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// routing: each regulator sees a pin only when its select bit is set

assign lin3_sel = {pin3_converter_select_r[`EPR_CNV_LIN10], pin3_converter_select_r[`EPR_CNV_LIN9],
   pin3_linear_select_r};
assign lin4_sel = {pin4_converter_select_r[`EPR_CNV_LIN10], pin4_converter_select_r[`EPR_CNV_LIN9],
   pin4_linear_select_r};
assign buck3_sel = pin3_converter_select_r[`EPR_CNV_BUCK_HI:`EPR_CNV_BUCK_LO];
assign buck4_sel = pin4_converter_select_r[`EPR_CNV_BUCK_HI:`EPR_CNV_BUCK_LO];

always @(posedge sys_clk) begin
   if (!resetn) begin
      linear_pin_enable <= `EPR_ZERO_10;
      buck_pin_enable <= `EPR_ZERO_4;
      linear_pin3_route <= `EPR_ZERO_10;
      buck_pin3_route <= `EPR_ZERO_4;
      linear_pin4_route <= `EPR_ZERO_10;
      buck_pin4_route <= `EPR_ZERO_4;
   end else begin
      linear_pin3_route <= lin3_sel;
      buck_pin3_route <= buck3_sel;
      linear_pin4_route <= lin4_sel;
      buck_pin4_route <= buck4_sel;
      // cleared bit gates the pin out entirely
      linear_pin_enable <= ({10{pin3_sync_r[1]}} & lin3_sel) |
         ({10{pin4_sync_r[1]}} & lin4_sel);
      buck_pin_enable <= ({4{pin3_sync_r[1]}} & buck3_sel) |
         ({4{pin4_sync_r[1]}} & buck4_sel);
   end
end

endmodule // epr_regs

`default_nettype wire

/* verif/epr_regs_properties.sv */
// checker of the routing bank bus answers, read fields, reset and pin gating
`timescale 1ns/100ps
`default_nettype none
module epr_chk (
   input wire logic sys_clk, resetn, avs_read, avs_waitrequest,
   input wire logic third_enable_pin, fourth_enable_pin,
   input wire logic [9:0] avs_address, linear_pin_enable, linear_pin3_route, linear_pin4_route,
   input wire logic [31:0] avs_readdata,
   input wire logic [3:0] buck_pin_enable, buck_pin3_route, buck_pin4_route
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic rd_ok;
   assign rd_ok = !avs_waitrequest && avs_read;
   ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
   answer_next_a: assert property ($rose(avs_read) |=> !avs_waitrequest) else $error("no answer");
   lin3_read_a: assert property (rd_ok && avs_address == 10'h0cc |->
      avs_readdata == {24'h00_0000, linear_pin3_route[7:0]}) else $error("33h read");
   cnv3_read_a: assert property (rd_ok && avs_address == 10'h0d0 |->
      avs_readdata == {26'h0, buck_pin3_route, linear_pin3_route[9:8]}) else $error("34h read");
   lin4_read_a: assert property (rd_ok && avs_address == 10'h0d4 |->
      avs_readdata == {24'h00_0000, linear_pin4_route[7:0]}) else $error("35h read");
   cnv4_read_a: assert property (rd_ok && avs_address == 10'h0d8 |->
      avs_readdata == {26'h0, buck_pin4_route, linear_pin4_route[9:8]}) else $error("36h read");
   reset_dflt_a: assert property (disable iff (1'b0) !resetn ##1 resetn |=>
      {linear_pin3_route, buck_pin3_route, linear_pin4_route, buck_pin4_route} == '0)
      else $error("reset defaults");
   pins_off_a: assert property ((!third_enable_pin && !fourth_enable_pin)[*4] |=>
      linear_pin_enable == 10'h000 && buck_pin_enable == 4'h0) else $error("pins off");
endmodule // epr_chk
bind epr_regs epr_chk epr_chk_i (.*);
`default_nettype wire

/* verif/epr_regs_tb.sv */
// self-checking bench of the enable pin routing register bank
`timescale 1ns/100ps
`default_nettype none
module epr_regs_tb;
   logic sys_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic third_enable_pin = 0, fourth_enable_pin = 0;
   logic [9:0] avs_address = '0, linear_pin_enable, linear_pin3_route, linear_pin4_route;
   logic [31:0] avs_writedata = '0, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'hf, buck_pin_enable, buck_pin3_route, buck_pin4_route;
   logic [1:0] avs_response, rsp;
   int miscompares = 0, total_checks = 0, cyc = 0;
   epr_regs epr_regs_i (.*);
   initial forever #2.5 sys_clk = ~sys_clk;
   // generous ceiling: the whole run is about 113 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // idle edge after release keeps one assignment per time step
   task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_write <= 0;
      avs_read <= 0;
      @(posedge sys_clk);
   endtask
   task t_defaults;
      for (int i = 0; i < 4; i++) begin
         acc(0, 10'h0cc + 10'(4 * i), '0);
         chk("default", rd, 32'h0000_0000);
         chk("response", {30'h0, rsp}, 32'h0000_0000);
      end
   endtask
   task t_fields(input logic [31:0] v[4], input logic [31:0] e[4]);
      for (int i = 0; i < 4; i++) acc(1, 10'h0cc + 10'(4 * i), v[i]);
      for (int i = 0; i < 4; i++) begin
         acc(0, 10'h0cc + 10'(4 * i), '0);
         chk("field", rd, e[i]);
      end
   endtask
   task t_pins(input logic a, input logic b, input logic [13:0] e);
      third_enable_pin <= a;
      fourth_enable_pin <= b;
      repeat (5) @(posedge sys_clk);
      chk("pin enable", {18'h0, buck_pin_enable, linear_pin_enable}, {18'h0, e});
   endtask
   task t_misc;
      avs_byteenable <= 4'h0;
      acc(1, 10'h0cc, 32'h0000_0000);
      avs_byteenable <= 4'hf;
      acc(0, 10'h0cc, '0);
      chk("no byte write", rd, 32'h0000_00a5);
      acc(0, 10'h0dc, '0);
      chk("unmapped", {rd[29:0], rsp}, 32'h0000_0002);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1;
      @(posedge sys_clk);
      t_defaults;
      t_fields('{32'hff, 32'hff, 32'hff, 32'hff}, '{32'hff, 32'h3f, 32'hff, 32'h3f});
      t_fields('{32'ha5, 32'hda, 32'h5a, 32'h25}, '{32'ha5, 32'h1a, 32'h5a, 32'h25});
      chk("routes", {linear_pin3_route, buck_pin3_route, 8'h0}, {10'h2a5, 4'h6, 8'h0});
      chk("routes", {linear_pin4_route, buck_pin4_route, 8'h0}, {10'h15a, 4'h9, 8'h0});
      t_pins(1, 0, {4'h6, 10'h2a5});
      t_pins(0, 1, {4'h9, 10'h15a});
      t_pins(1, 1, {4'hf, 10'h3ff});
      t_pins(0, 0, 14'h0000);
      t_misc;
      resetn <= 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1;
      @(posedge sys_clk);
      t_defaults;
      close_out;
   end
endmodule // epr_regs_tb
`default_nettype wire
